//--- sapm_pkg.sv
// shared constants and types for the sdram auto power manager
`default_nettype none
package sapm_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_EXIT   = 4'h4;
  localparam logic [3:0]  ADDR_STAT   = 4'h8;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK  = 32'h0000_f7f0;
  localparam logic [31:0] EXIT_WMASK  = 32'h0000_000f;
  localparam int          PD_LSB      = 12;
  localparam int          LP_LSB      = 8;
  localparam int          SR_LSB      = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // modes and timing
  // ------------------------------------------------------------
  localparam logic [2:0]  LP_SELFREF  = 3'h2;
  localparam logic [2:0]  LP_PWRDOWN  = 3'h4;
  localparam logic [18:0] THR_BASE    = 19'h0_0010;
  localparam int          CNT_W       = 19;
  localparam logic [4:0]  EXIT_EXTRA  = 5'h01;

  typedef struct packed {
    logic [3:0] powerdown_idle_timer;
    logic [2:0] lp_sel;
    logic [3:0] selfrefresh_idle_timer;
  } sapm_ctrl_t;

  typedef enum logic [1:0] {
    ST_AWAKE = 2'b00,
    ST_LOW   = 2'b01,
    ST_EXIT  = 2'b11
  } sapm_state_t;

  // idle threshold in clocks for a 4-bit timer code
  function automatic logic [CNT_W-1:0] idle_threshold(
    input logic [3:0] code
  );
    logic [CNT_W-1:0] t;
    t = '0;
    if (code != 4'h0)
      t = THR_BASE << (code - 4'h1);
    return t;
  endfunction
endpackage
`default_nettype wire

//--- sapm_idle_timer.sv
// idle cycle counter with programmable threshold
`default_nettype none
module sapm_idle_timer
  import sapm_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic       activity,
  input  wire logic [3:0] code,
  output var  logic       expired
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] thr;

  // ------------------------------------------------------------
  // counting
  // ------------------------------------------------------------
  always_comb
  begin
    thr        = idle_threshold(code);
    next_count = count;
    if (count != {CNT_W{1'b1}})
      next_count = count + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= '0;
    else if (!enable || activity)
      count <= '0;
    else
      count <= next_count;
  end

  // code 0 gives threshold 0: expires on first idle cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      expired <= 1'b0;
    else
      expired <= enable && !activity && (next_count >= thr);
  end
endmodule
`default_nettype wire

//--- sapm_top.sv
// sdram auto power manager with axi4-lite register slave
`default_nettype none
module sapm_top
  import sapm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cmd_pending,
  input  wire logic        cmd_issued,
  input  wire logic        access_req,
  output var  logic        powerdown_active,
  output var  logic        selfrefresh_active,
  output var  logic        cmd_allowed,
  output var  logic        read_allowed
);
  sapm_ctrl_t  ctrl;
  logic [3:0]  powerdown_exit_delay;
  sapm_state_t state;
  sapm_state_t next_state;
  logic        low_is_sr;
  logic [4:0]  exit_cnt;
  logic        aw_got;
  logic        w_got;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        mode_pd;
  logic        mode_sr;
  logic        activity;
  logic        timer_en;
  logic        expired;
  logic [3:0]  timer_code;
  logic [31:0] ctrl_word;
  logic [31:0] wmask;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  always_comb
  begin
    mode_pd    = (ctrl.lp_sel == LP_PWRDOWN);
    mode_sr    = (ctrl.lp_sel == LP_SELFREF);
    timer_code = mode_sr ? ctrl.selfrefresh_idle_timer : ctrl.powerdown_idle_timer;
    activity   = cmd_pending || cmd_issued || access_req;
    timer_en   = (mode_pd || mode_sr) && (state == ST_AWAKE);
    do_write   = aw_got && w_got && !s_axi_bvalid;
    wmask      = strb_mask(w_strb);
    ctrl_word  = CTRL_RESET;
    ctrl_word[PD_LSB +: 4] = ctrl.powerdown_idle_timer;
    ctrl_word[LP_LSB +: 3] = ctrl.lp_sel;
    ctrl_word[SR_LSB +: 4] = ctrl.selfrefresh_idle_timer;
  end

  sapm_idle_timer u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .enable   (timer_en),
    .activity (activity),
    .code     (timer_code),
    .expired  (expired)
  );

  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got        <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got        <= 1'b1;
      aw_addr       <= s_axi_awaddr[3:0];
      s_axi_awready <= 1'b0;
    end
    else
    begin
      if (do_write)
        aw_got <= 1'b0;
      s_axi_awready <= !aw_got && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got        <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got        <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (do_write)
        w_got <= 1'b0;
      s_axi_wready <= !w_got && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_EXIT ||
                       aw_addr == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // reserved bits are masked out of the stored value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl                 <= '0;
      powerdown_exit_delay <= '0;
    end
    else if (do_write && aw_addr == ADDR_CTRL)
    begin
      if ((CTRL_WMASK & wmask) != '0)
      begin
        if (wmask[PD_LSB])
          ctrl.powerdown_idle_timer <= w_data[PD_LSB +: 4];
        if (wmask[LP_LSB])
          ctrl.lp_sel <= w_data[LP_LSB +: 3];
        if (wmask[SR_LSB])
          ctrl.selfrefresh_idle_timer <= w_data[SR_LSB +: 4];
      end
    end
    else if (do_write && aw_addr == ADDR_EXIT && (EXIT_WMASK & wmask) != '0)
      powerdown_exit_delay <= w_data[3:0];
  end

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr[3:0])
        ADDR_CTRL: s_axi_rdata <= ctrl_word;
        ADDR_EXIT: s_axi_rdata <= {28'h000_0000, powerdown_exit_delay};
        ADDR_STAT: s_axi_rdata <= {27'h000_0000, exit_cnt != '0,
                                   low_is_sr, state == ST_LOW, state};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end

  // ------------------------------------------------------------
  // power state machine
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_AWAKE:
        if (expired && timer_en && !activity)
          next_state = ST_LOW;
      ST_LOW:
        if (activity || !(mode_pd || mode_sr))
          next_state = ST_EXIT;
      ST_EXIT:
        if (exit_cnt == 5'h01)
          next_state = ST_AWAKE;
      default:
        next_state = ST_AWAKE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= ST_AWAKE;
    else
      state <= next_state;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      low_is_sr <= 1'b0;
    else if (state == ST_AWAKE && next_state == ST_LOW)
      low_is_sr <= mode_sr;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      exit_cnt <= '0;
    else if (state == ST_LOW && next_state == ST_EXIT)
      exit_cnt <= {1'b0, powerdown_exit_delay} + EXIT_EXTRA;
    else if (exit_cnt != '0)
      exit_cnt <= exit_cnt - 5'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      powerdown_active   <= 1'b0;
      selfrefresh_active <= 1'b0;
      cmd_allowed        <= 1'b1;
      read_allowed       <= 1'b1;
    end
    else
    begin
      powerdown_active   <= (next_state == ST_LOW) &&
                            (state == ST_LOW ? !low_is_sr : mode_pd);
      selfrefresh_active <= (next_state == ST_LOW) &&
                            (state == ST_LOW ? low_is_sr : mode_sr);
      cmd_allowed        <= (next_state == ST_AWAKE);
      read_allowed       <= (next_state != ST_LOW);
    end
  end
endmodule
`default_nettype wire

//--- sapm_props.sv
// port assertions for the sdram auto power manager
`default_nettype none
module sapm_props
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cmd_pending,
  input  wire logic        access_req,
  input  wire logic        powerdown_active,
  input  wire logic        selfrefresh_active,
  input  wire logic        cmd_allowed,
  input  wire logic        read_allowed,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic in_low = powerdown_active || selfrefresh_active;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_busy;
    cmd_pending [*3];
  endsequence
  property p_one; !(powerdown_active && selfrefresh_active); endproperty
  a_one: assert property (p_one)
    else $error("both low-power states");
  property p_wake; access_req |=> !in_low; endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on request");
  property p_block; in_low |-> !cmd_allowed && !read_allowed; endproperty
  a_block: assert property (p_block)
    else $error("command allowed while low");
  property p_exit; $fell(in_low) |-> read_allowed && !cmd_allowed; endproperty
  a_exit: assert property (p_exit)
    else $error("exit wait missing");
  property p_busy; s_busy |-> !$rose(in_low); endproperty
  a_busy: assert property (p_busy)
    else $error("entered low while busy");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans)
    else $error("read answer late");
  property p_rsv; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_rsv: assert property (p_rsv)
    else $error("upper read bits set");
endmodule
bind sapm_top sapm_props u_props (.*);
`default_nettype wire

//--- sapm_sdram_model.sv
// behavioural sdram clock-enable and self-refresh tracker
`default_nettype none
module sapm_sdram_model
(
  input  wire logic       aclk,
  input  wire logic       powerdown_active,
  input  wire logic       selfrefresh_active,
  output var  logic       cke,
  output var  logic [7:0] sr_entries
);
  timeunit 1ns;
  timeprecision 1ps;
  logic was_sr = 1'b0;
  initial sr_entries = 8'h00;
  assign cke = !(powerdown_active || selfrefresh_active);
  always @(posedge aclk)
  begin
    if (selfrefresh_active && !was_sr)
      sr_entries <= sr_entries + 8'h01;
    was_sr <= selfrefresh_active;
  end
endmodule
`default_nettype wire

//--- sdram_auto_power_manager_test.sv
// self-checking bench for the sdram auto power manager
`default_nettype none
module sdram_auto_power_manager_test
  import sapm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, cmd_pending = 1'b0;
  logic        cmd_issued = 1'b0, access_req = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, powerdown_active;
  logic        selfrefresh_active, cmd_allowed, read_allowed, cke;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, d;
  logic [7:0]  sr_entries;
  int          err_count = 0, num_checks = 0, n, c, t;
  sapm_top dut_u (.*);
  sapm_sdram_model mem_u (.*);
  always #2 aclk = ~aclk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, s);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, v);
    bit aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (s_axi_awready) aw = 0;
      if (s_axi_wready) w = 0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic idle(input int lim);
    @(posedge aclk);
    cmd_pending <= 1'b0;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!(powerdown_active || selfrefresh_active) && n < lim);
  endtask
  task automatic wake();
    @(posedge aclk);
    access_req <= 1'b1;
    cmd_pending <= 1'b1;
    @(posedge aclk);
    access_req <= 1'b0;
    @(posedge aclk);
    chk("exit read", 32'h1, read_allowed);
    n = 1;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (cmd_allowed !== 1'b1 && n < 50);
    chk("exit wait", 32'h5, (n >= 4 && n <= 6) ? 5 : n);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h0);
    chk("ctrl reset", CTRL_RESET, d);
    wr(32'h0, 32'hffff_ffff);
    rd(32'h0);
    chk("ctrl reserved", 32'h0000_f7f0, d);
    wr(32'hc, 32'h1);
    chk("bad wr resp", RESP_SLVERR, rsp);
    rd(32'hc);
    chk("bad rd resp", RESP_SLVERR, rsp);
    wr(32'(ADDR_EXIT), 32'h3);
    for (c = 0; c < 8; c++)
      if (c != 2 && c != 4)
      begin
        cmd_pending <= 1'b1;
        wr(32'h0, 32'(c) << 8 | 32'h0000_1010);
        idle(100);
        chk("lp off", 32'h64, n);
      end
    for (c = 0; c < 4; c++)
    begin
      cmd_pending <= 1'b1;
      t = (c == 0) ? 0 : 16 << (c - 1);
      wr(32'h0, 32'(c) << 12 | 32'h0000_0400);
      idle(300);
      chk("pd idle", t, (n >= t && n <= t + 4) ? t : n);
      rd(32'(ADDR_STAT));
      chk("pd status", 32'h5, d);
      chk("pd cke", 32'h0, cke);
      chk("pd read", 32'h0, read_allowed);
      wake();
    end
    wr(32'h0, 32'h0000_3210);
    idle(300);
    chk("sr idle", 32'h10, (n >= 16 && n <= 20) ? 16 : n);
    @(posedge aclk);
    chk("sr entries", 32'h1, sr_entries);
    chk("sr pd off", 32'h0, powerdown_active);
    wake();
    wr(32'h0, 32'h0000_1400);
    repeat (100) @(posedge aclk);
    chk("busy awake", 32'h0, powerdown_active);
    cmd_pending <= 1'b0;
    repeat (10)
    begin
      repeat (9) @(posedge aclk);
      cmd_issued <= 1'b1;
      @(posedge aclk);
      cmd_issued <= 1'b0;
    end
    chk("issued awake", 32'h0, powerdown_active);
    give_verdict();
  end
  initial
  begin
    #100000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
